// ==== rtl/ppss_pkg.sv ====
package ppss_pkg;
  localparam logic [31:0] PPSS_PLL_CTRL_ADDR   = 32'h0231_0100;
  localparam logic [31:0] PPSS_IRQ_STATUS_ADDR = 32'h0231_0104;
  localparam logic [31:0] PPSS_IRQ_MASK_ADDR   = 32'h0231_0108;
  localparam logic [31:0] PPSS_STATUS_ADDR     = 32'h0231_010c;
  localparam int          PPSS_BYPASS_BIT      = 0;
  localparam int          PPSS_PWRDN_BIT       = 1;
  localparam int          PPSS_CTRL_USED_W     = 8;
  localparam logic [31:0] PPSS_CTRL_RESET      = 32'h0000_0001;
  localparam logic [2:0]  PPSS_BOOT_NONE       = 3'h0;
  localparam logic [2:0]  PPSS_BOOT_SPI        = 3'h1;
  localparam logic [2:0]  PPSS_BOOT_I2C        = 3'h2;
  localparam int          PPSS_PWRDN_MIN_NS    = 5000;
  localparam int          PPSS_CLK_NS          = 100;
  localparam int          PPSS_PWRDN_CYC       = (PPSS_PWRDN_MIN_NS + PPSS_CLK_NS - 1) / PPSS_CLK_NS;
  localparam int          PPSS_CNT_W           = 8;
  typedef enum logic [1:0] {PPSS_ST_STRAP, PPSS_ST_INIT, PPSS_ST_DONE} ppss_state_e;
endpackage : ppss_pkg

// ==== rtl/ppss_top.sv ====
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ppss_top (
  input  wire logic        clk_i,          // 10 MHz reference
  input  wire logic        rst_i,          // async power-on reset
  input  wire logic [31:0] paddr_i,        // apb address
  input  wire logic        psel_i,         // apb select
  input  wire logic        penable_i,      // apb enable
  input  wire logic        pwrite_i,       // apb direction
  input  wire logic [31:0] pwdata_i,       // apb write data
  output logic      [31:0] prdata_o,       // apb read data
  output logic             pready_o,       // apb ready
  output logic             pslverr_o,      // apb error
  input  wire logic [2:0]  boot_select_pins_i, // boot mode straps
  input  wire logic [2:0]  pll_locked_i,   // analog lock: main, memory, packet
  output logic             pll_power_down_o, // to all three PLLs
  output logic             main_pll_bypass_o, // main PLL bypass
  output logic             main_lock_pin_o,  // main lock indicator
  output logic             memory_lock_pin_o, // memory lock indicator
  output logic             packet_lock_pin_o, // packet lock indicator
  output logic             irq_o           // level interrupt
);
  import ppss_pkg::*;

  ppss_state_e             st_reg, st_next;
  logic [2:0]              boot_reg, boot_next;
  logic [31:0]             ctrl_reg, ctrl_next;
  logic [3:0]              stat_reg, stat_next;
  logic [3:0]              mask_reg, mask_next;
  logic [2:0]              lock_reg, lock_next;
  logic [31:0]             rdata_reg, rdata_next;
  logic [PPSS_CNT_W-1:0]   pd_cnt_reg, pd_cnt_next;
  logic                    pd_short_reg, pd_short_next;
  logic                    wr_en, rd_en, hit;
  logic [3:0]              ev;

  function automatic logic auto_cfg_mode(input logic [2:0] m);
    auto_cfg_mode = !(m == PPSS_BOOT_NONE || m == PPSS_BOOT_SPI || m == PPSS_BOOT_I2C);
  endfunction : auto_cfg_mode

  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && !penable_i && !pwrite_i;
  assign hit   = (paddr_i == PPSS_PLL_CTRL_ADDR) || (paddr_i == PPSS_IRQ_STATUS_ADDR) ||
                 (paddr_i == PPSS_IRQ_MASK_ADDR) || (paddr_i == PPSS_STATUS_ADDR);

  always_comb begin
    st_next       = st_reg;
    boot_next     = boot_reg;
    ctrl_next     = ctrl_reg;
    mask_next     = mask_reg;
    rdata_next    = rdata_reg;
    pd_cnt_next   = pd_cnt_reg;
    pd_short_next = pd_short_reg;
    lock_next     = pll_locked_i;
    // events: lock gained on each PLL, power-down pulse shorter than minimum
    ev = {1'b0, pll_locked_i & ~lock_reg};
    case (st_reg)
      PPSS_ST_STRAP: begin
        // straps caught by a clocked process after reset release
        boot_next = boot_select_pins_i;
        st_next   = PPSS_ST_INIT;
      end
      PPSS_ST_INIT: begin
        // built-in init leaves the power-down bit alone; only bypass moves
        if (auto_cfg_mode(boot_reg)) begin
          ctrl_next[PPSS_BYPASS_BIT] = 1'b0;
        end
        st_next = PPSS_ST_DONE;
      end
      PPSS_ST_DONE: st_next = PPSS_ST_DONE;
      default:      st_next = PPSS_ST_STRAP;
    endcase
    // pulse width watch: flags a pulse released before 5 us
    if (ctrl_reg[PPSS_PWRDN_BIT]) begin
      if (pd_cnt_reg != PPSS_CNT_W'(PPSS_PWRDN_CYC)) begin
        pd_cnt_next = pd_cnt_reg + PPSS_CNT_W'(1);
      end
    end else begin
      pd_cnt_next = '0;
    end
    if (wr_en && paddr_i == PPSS_PLL_CTRL_ADDR) begin
      // low 8 bits stored, upper bits zeroed; software keeps other bits via read-modify-write
      ctrl_next = {{(32-PPSS_CTRL_USED_W){1'b0}}, pwdata_i[PPSS_CTRL_USED_W-1:0]};
      // the clearing edge is itself the last high cycle, hence minimum minus one
      if (ctrl_reg[PPSS_PWRDN_BIT] && !pwdata_i[PPSS_PWRDN_BIT] &&
          pd_cnt_reg < PPSS_CNT_W'(PPSS_PWRDN_CYC - 1)) begin
        ev[3] = 1'b1;
      end
    end
    if (ev[3]) begin
      pd_short_next = 1'b1;
    end
    if (wr_en && paddr_i == PPSS_IRQ_MASK_ADDR) begin
      mask_next = pwdata_i[3:0];
    end
    stat_next = stat_reg;
    if (wr_en && paddr_i == PPSS_IRQ_STATUS_ADDR) begin
      stat_next = stat_reg & ~pwdata_i[3:0];
    end
    stat_next = stat_next | ev; // set wins over clear
    if (rd_en) begin
      case (paddr_i)
        PPSS_PLL_CTRL_ADDR:   rdata_next = ctrl_reg;
        PPSS_IRQ_STATUS_ADDR: rdata_next = {28'h0, stat_reg};
        PPSS_IRQ_MASK_ADDR:   rdata_next = {28'h0, mask_reg};
        PPSS_STATUS_ADDR:     rdata_next = {24'h0, pd_short_reg, boot_reg, 1'b0, lock_reg};
        default:              rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg       <= PPSS_ST_STRAP;
      boot_reg     <= 3'h0;
      ctrl_reg     <= PPSS_CTRL_RESET;
      stat_reg     <= 4'h0;
      mask_reg     <= 4'h0;
      lock_reg     <= 3'h0;
      rdata_reg    <= 32'h0000_0000;
      pd_cnt_reg   <= '0;
      pd_short_reg <= 1'b0;
    end else begin
      st_reg       <= st_next;
      boot_reg     <= boot_next;
      ctrl_reg     <= ctrl_next;
      stat_reg     <= stat_next;
      mask_reg     <= mask_next;
      lock_reg     <= lock_next;
      rdata_reg    <= rdata_next;
      pd_cnt_reg   <= pd_cnt_next;
      pd_short_reg <= pd_short_next;
    end
  end

  assign prdata_o          = rdata_reg;
  assign pready_o          = 1'b1;
  assign pslverr_o         = psel_i && penable_i && !hit;
  assign pll_power_down_o  = ctrl_reg[PPSS_PWRDN_BIT];
  assign main_pll_bypass_o = ctrl_reg[PPSS_BYPASS_BIT];
  assign main_lock_pin_o   = lock_reg[0];
  assign memory_lock_pin_o = lock_reg[1];
  assign packet_lock_pin_o = lock_reg[2];
  assign irq_o             = |(stat_reg & mask_reg);

  a_bypass_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg == PPSS_ST_INIT && !auto_cfg_mode(boot_reg) && !(wr_en && paddr_i == PPSS_PLL_CTRL_ADDR))
    |=> main_pll_bypass_o)
    else $error("main PLL left bypass in a manual boot mode");
  a_pll_mode_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg == PPSS_ST_INIT && auto_cfg_mode(boot_reg) && !(wr_en && paddr_i == PPSS_PLL_CTRL_ADDR))
    |=> !main_pll_bypass_o)
    else $error("main PLL not moved to PLL mode");
  a_pwrdn_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_en && paddr_i == PPSS_PLL_CTRL_ADDR) |=> pll_power_down_o == $past(pwdata_i[PPSS_PWRDN_BIT]))
    else $error("power-down output does not follow the written bit");
  a_init_no_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg != PPSS_ST_DONE && !wr_en) |=> $stable(pll_power_down_o))
    else $error("built-in init touched the power-down bit");
  a_lock_track: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 {main_lock_pin_o, memory_lock_pin_o, packet_lock_pin_o} ==
        {$past(pll_locked_i[0]), $past(pll_locked_i[1]), $past(pll_locked_i[2])})
    else $error("lock pins do not follow PLL lock");
  a_short_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_en && paddr_i == PPSS_PLL_CTRL_ADDR && pll_power_down_o && !pwdata_i[PPSS_PWRDN_BIT] &&
     pd_cnt_reg < PPSS_CNT_W'(PPSS_PWRDN_CYC - 1)) |=> stat_reg[3])
    else $error("short power-down pulse not flagged");
  a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == |(stat_reg & mask_reg))
    else $error("interrupt output mismatch");
  // sampled rst_i keeps the release edge, where the core is still held, out of the check
  a_init_ends: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg == PPSS_ST_STRAP && !rst_i) |=> st_reg == PPSS_ST_INIT ##1 st_reg == PPSS_ST_DONE)
    else $error("start-up sequence did not finish in two cycles");

  // lock gains latch into status at the same edge that raises the pin
  a_main_lock_evt: assert property (@(posedge clk_i) disable iff (rst_i)
    (pll_locked_i[0] && !main_lock_pin_o) |=> (stat_reg[0] && main_lock_pin_o))
    else $error("main PLL lock gain not latched");
  a_mem_lock_evt: assert property (@(posedge clk_i) disable iff (rst_i)
    (pll_locked_i[1] && !memory_lock_pin_o) |=> (stat_reg[1] && memory_lock_pin_o))
    else $error("memory PLL lock gain not latched");
  a_pkt_lock_evt: assert property (@(posedge clk_i) disable iff (rst_i)
    (pll_locked_i[2] && !packet_lock_pin_o) |=> (stat_reg[2] && packet_lock_pin_o))
    else $error("packet PLL lock gain not latched");
  a_main_lock_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pll_locked_i[0] && main_lock_pin_o) |=> !main_lock_pin_o)
    else $error("main lock pin stayed high after lock loss");
  a_mem_lock_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pll_locked_i[1] && memory_lock_pin_o) |=> !memory_lock_pin_o)
    else $error("memory lock pin stayed high after lock loss");
  a_pkt_lock_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pll_locked_i[2] && packet_lock_pin_o) |=> !packet_lock_pin_o)
    else $error("packet lock pin stayed high after lock loss");
  a_stat_w1c: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_en && paddr_i == PPSS_IRQ_STATUS_ADDR && pwdata_i[0] && !(pll_locked_i[0] && !lock_reg[0]))
    |=> !stat_reg[0])
    else $error("status bit survived its clear");
  a_short_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    pd_short_reg |=> pd_short_reg)
    else $error("short-pulse record lost");
  a_cnt_bounded: assert property (@(posedge clk_i) disable iff (rst_i)
    pd_cnt_reg <= PPSS_CNT_W'(PPSS_PWRDN_CYC))
    else $error("pulse width counter ran past its limit");
  a_ctrl_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_reg[31:PPSS_CTRL_USED_W] == '0)
    else $error("unused control bits hold a value");

  // power-down moves only on a control write; bypass also at the boot step
  a_pwrdn_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr_en && paddr_i == PPSS_PLL_CTRL_ADDR) |=> $stable(pll_power_down_o))
    else $error("power-down output moved without a write");
  a_bypass_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg != PPSS_ST_INIT && !(wr_en && paddr_i == PPSS_PLL_CTRL_ADDR)) |=> $stable(main_pll_bypass_o))
    else $error("bypass moved outside boot step and writes");
  a_boot_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg == PPSS_ST_STRAP && !rst_i) |=> boot_reg == $past(boot_select_pins_i))
    else $error("boot straps not captured");
  a_ready_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (psel_i && penable_i) |-> pready_o)
    else $error("access phase without ready");
  a_err_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    (psel_i && penable_i) |-> (pslverr_o == !hit))
    else $error("error response does not match address decode");
  a_mask_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_en && paddr_i == PPSS_IRQ_MASK_ADDR) |=> prdata_o == {28'h0, $past(mask_reg)})
    else $error("mask read returned wrong data");
endmodule : ppss_top
`default_nettype wire

// ==== tb/ppss_pll_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ppss_pll_model
  import ppss_pkg::*;
#(
  parameter int LOCK_CYC = 20
) (
  input  wire logic       clk_i,   // reference clock
  input  wire logic       rst_i,   // power-on reset
  input  wire logic       pd_i,    // shared power-down input
  output logic      [2:0] locked_o // main, memory, packet
);
  int   hi_cnt;
  int   lk_cnt;
  logic armed;
  // a pulse shorter than the minimum leaves the macros unable to lock
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hi_cnt   <= 0;
      lk_cnt   <= 0;
      armed    <= 1'b0;
      locked_o <= 3'h0;
    end else if (pd_i) begin
      hi_cnt   <= hi_cnt + 1;
      armed    <= (hi_cnt + 1 >= PPSS_PWRDN_CYC);
      lk_cnt   <= 0;
      locked_o <= 3'h0;
    end else begin
      // width counts one pulse only; a short pulse never adds to the next
      hi_cnt <= 0;
      if (armed) begin
        lk_cnt <= lk_cnt + 1;
        if (lk_cnt == LOCK_CYC) begin
          locked_o <= 3'h7;
        end
      end
    end
  end
endmodule : ppss_pll_model
`default_nettype wire

// ==== tb/ppss_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module ppss_top_bench;
  import ppss_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [31:0] paddr_i = '0, pwdata_i = '0, prdata_o, rd;
  logic [2:0]  boot_select_pins_i = '0, pll_locked_i;
  logic        pready_o, pslverr_o, pll_power_down_o, main_pll_bypass_o, irq_o, err;
  logic        main_lock_pin_o, memory_lock_pin_o, packet_lock_pin_o;
  int          err_total = 0, n_compared = 0;
  always #50 clk_i = ~clk_i;
  ppss_top u_dut (.clk_i, .rst_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .boot_select_pins_i, .pll_locked_i, .pll_power_down_o, .main_pll_bypass_o, .main_lock_pin_o,
    .memory_lock_pin_o, .packet_lock_pin_o, .irq_o);
  ppss_pll_model u_pll (.clk_i(clk_i), .rst_i(rst_i), .pd_i(pll_power_down_o), .locked_o(pll_locked_i));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic t_boot();
    for (int m = 7; m >= 0; m--) begin
      boot_select_pins_i <= m[2:0];
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk(main_pll_bypass_o, m < 3);
      apb(1'b0, PPSS_PLL_CTRL_ADDR, '0);
      chk(rd, (m < 3) ? PPSS_CTRL_RESET : 32'h0);
    end
  endtask : t_boot
  task automatic t_pulse();
    logic [31:0] c;
    // I2C straps select a manual boot mode, so the main PLL stays in bypass
    boot_select_pins_i <= PPSS_BOOT_I2C;
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(main_pll_bypass_o, 1'b1);
    apb(1'b0, PPSS_STATUS_ADDR, '0);
    chk(rd, {24'h0, 1'b0, PPSS_BOOT_I2C, 4'h0});
    apb(1'b1, PPSS_IRQ_MASK_ADDR, 32'h7);
    apb(1'b1, PPSS_PLL_CTRL_ADDR, 32'h5d);
    apb(1'b0, PPSS_PLL_CTRL_ADDR, '0);
    c = rd;
    chk(c, 32'h5d);
    apb(1'b1, PPSS_PLL_CTRL_ADDR, c | 32'h2);
    @(negedge clk_i);
    chk(pll_power_down_o, 1'b1);
    // the clearing write spends three edges, so the bit stands exactly the minimum
    repeat (PPSS_PWRDN_CYC - 3) @(posedge clk_i);
    apb(1'b1, PPSS_PLL_CTRL_ADDR, c);
    @(negedge clk_i);
    chk(pll_power_down_o, 1'b0);
    // lock wait bounded well past the model's lock time
    for (int i = 0; i < 100 && irq_o !== 1'b1; i++) @(posedge clk_i);
    @(negedge clk_i);
    chk({packet_lock_pin_o, memory_lock_pin_o, main_lock_pin_o}, 3'h7);
    apb(1'b1, PPSS_PLL_CTRL_ADDR, c & ~32'h1);
    @(negedge clk_i);
    chk(main_pll_bypass_o, 1'b0);
    apb(1'b0, PPSS_IRQ_STATUS_ADDR, '0);
    chk(rd & 32'hf, 32'h7);
    apb(1'b1, PPSS_IRQ_STATUS_ADDR, 32'h7);
    @(negedge clk_i);
    chk(irq_o, 1'b0);
    apb(1'b1, PPSS_PLL_CTRL_ADDR, c | 32'h2);
    apb(1'b1, PPSS_PLL_CTRL_ADDR, c);
    apb(1'b0, PPSS_IRQ_STATUS_ADDR, '0);
    chk(rd[3], 1'b1);
    repeat (40) @(posedge clk_i);
    @(negedge clk_i);
    chk({packet_lock_pin_o, memory_lock_pin_o, main_lock_pin_o}, 3'h0);
    apb(1'b0, PPSS_STATUS_ADDR, '0);
    chk(rd, {24'h0, 1'b1, PPSS_BOOT_I2C, 4'h0});
    apb(1'b1, PPSS_IRQ_MASK_ADDR, 32'h8);
    @(negedge clk_i);
    chk(irq_o, 1'b1);
  endtask : t_pulse
  task automatic t_unmapped();
    apb(1'b0, PPSS_STATUS_ADDR + 32'h4, '0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
  endtask : t_unmapped
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  initial begin
    t_boot();
    t_pulse();
    t_unmapped();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    report_and_stop();
  end
endmodule : ppss_top_bench
`default_nettype wire
